// [inc/ctt_pkg.sv]
// package: register map, field positions, reset values and state types of the capture/compare timer
`default_nettype none
package ctt_pkg;
	// register indices; byte address on the bus is four times the index
	localparam logic [7:0] IDX_CR2 = 8'h51;
	localparam logic [7:0] IDX_CR1 = 8'h52;
	localparam logic [7:0] IDX_CSR = 8'h53;
	localparam logic [7:0] IDX_IC1H = 8'h54;
	localparam logic [7:0] IDX_IC1L = 8'h55;
	localparam logic [7:0] IDX_OC1H = 8'h56;
	localparam logic [7:0] IDX_OC1L = 8'h57;
	localparam logic [7:0] IDX_CH = 8'h58;
	localparam logic [7:0] IDX_CL = 8'h59;
	localparam logic [7:0] IDX_ACH = 8'h5A;
	localparam logic [7:0] IDX_ACL = 8'h5B;
	localparam logic [7:0] IDX_IC2H = 8'h5C;
	localparam logic [7:0] IDX_IC2L = 8'h5D;
	localparam logic [7:0] IDX_OC2H = 8'h5E;
	localparam logic [7:0] IDX_OC2L = 8'h5F;
	// control_reg_one fields
	localparam int B_CAP_IRQ_EN = 7;
	localparam int B_CMP_IRQ_EN = 6;
	localparam int B_OVF_IRQ_EN = 5;
	localparam int B_FORCE_TWO = 4;
	localparam int B_FORCE_ONE = 3;
	localparam int B_LVL_TWO = 2;
	localparam int B_EDGE_ONE = 1;
	localparam int B_LVL_ONE = 0;
	// control_reg_two fields
	localparam int B_PIN_ONE_EN = 7;
	localparam int B_PIN_TWO_EN = 6;
	localparam int B_SINGLE_PULSE = 5;
	localparam int B_PWM = 4;
	localparam int B_CLK_HI = 3;
	localparam int B_CLK_LO = 2;
	localparam int B_EDGE_TWO = 1;
	localparam int B_EXT_EDGE = 0;
	// status register: flags sit in bits 7:3, timer disable in bit 2
	localparam int B_TIMD = 2;
	localparam int F_CAP1 = 4;
	localparam int F_CMP1 = 3;
	localparam int F_OVF = 2;
	localparam int F_CAP2 = 1;
	localparam int F_CMP2 = 0;
	localparam logic [4:0][7:0] FLAG_CLR_IDX = {IDX_IC1L, IDX_OC1L, IDX_CL, IDX_IC2L, IDX_OC2L};
	// clock_select encodings and prescaler masks
	localparam logic [1:0] CLK_DIV4 = 2'h0;
	localparam logic [1:0] CLK_DIV2 = 2'h1;
	localparam logic [1:0] CLK_DIV8 = 2'h2;
	localparam logic [1:0] CLK_EXT = 2'h3;
	localparam logic [2:0] MASK_DIV2 = 3'h1;
	localparam logic [2:0] MASK_DIV4 = 3'h3;
	localparam logic [2:0] MASK_DIV8 = 3'h7;
	// reset and load values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'hFFFC;
	localparam logic [15:0] SINGLE_CAPTURE = 16'hFFFD;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] CMP_RESET = 16'h8000;

	typedef struct packed {
		logic s1;
		logic s2;
		logic last;
	} ctt_sync_t;

	typedef struct packed {
		logic [7:0] cr1;
		logic [7:0] cr2;
		logic timd;
		logic [4:0] flags;
		logic [4:0] srSeen;
		logic [15:0] count;
		logic [15:0] capOne;
		logic [15:0] capTwo;
		logic [15:0] cmpOne;
		logic [15:0] cmpTwo;
		logic [15:0] actOne;
		logic [15:0] actTwo;
		logic [1:0] inhibit;
		logic pinOne;
		logic pinTwo;
		logic [1:0] capArm;
		logic haltPrev;
		logic ack;
		logic [7:0] rdat;
	} ctt_state_t;
endpackage
`default_nettype wire

// [hw/ctt_edge_sync.sv]
// two-flop pin synchroniser with selectable edge pulse
`default_nettype none
module ctt_edge_sync
	import ctt_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic pinIn,
	input wire logic risingSel,
	output logic pulse
);
	ctt_sync_t st;
	ctt_sync_t next_st;

	always_comb
	begin
		next_st.s1 = pinIn;
		next_st.s2 = st.s1;
		next_st.last = st.s2;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// 1 selects rising, 0 selects falling
	assign pulse = risingSel ? (st.s2 & ~st.last) : (~st.s2 & st.last);
endmodule
`default_nettype wire

// [hw/ctt_prescaler.sv]
// timer clock prescaler: cpu clock divided by 2, 4 or 8, or external clock edges
`default_nettype none
module ctt_prescaler
	import ctt_pkg::*;
#(
	parameter bit EXT_PRESENT = 1'b1
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic run,
	input wire logic [1:0] clockSelect,
	input wire logic extEdge,
	output logic tick
);
	logic [2:0] div;
	logic [2:0] next_div;
	logic [2:0] mask;

	always_comb
	begin
		next_div = run ? div + 3'h1 : div;
		case (clockSelect)
			CLK_DIV2: mask = MASK_DIV2;
			CLK_DIV8: mask = MASK_DIV8;
			default: mask = MASK_DIV4;
		endcase
		if (clockSelect == CLK_EXT)
		begin
			tick = run & extEdge & EXT_PRESENT;
		end
		else
		begin
			tick = run & ((div & mask) == mask);
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			div <= '0;
		end
		else
		begin
			div <= next_div;
		end
	end
endmodule
`default_nettype wire

// [hw/ctt_timer16.sv]
// 16-bit capture/compare timer with classic wishbone register slave
`default_nettype none
module ctt_timer16
	import ctt_pkg::*;
#(
	parameter int ADR_W = 10,
	parameter bit EXT_PRESENT = 1'b1
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [ADR_W-1:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatI,
	output logic [31:0] wbDatO,
	output logic wbAck,
	input wire logic capturePinOne,
	input wire logic capturePinTwo,
	input wire logic extClockPin,
	output logic comparePinOne,
	output logic comparePinOneEn,
	output logic comparePinTwo,
	output logic comparePinTwoEn,
	input wire logic cpuIntMask,
	input wire logic waitMode,
	input wire logic haltMode,
	output logic timerIrq,
	output logic waitWake
);
	ctt_state_t st;
	ctt_state_t next_st;
	logic capEdgeOne;
	logic capEdgeTwo;
	logic extEdge;
	logic tick;
	logic live;
	logic access;
	logic wr;
	logic rd;
	logic pwmOn;
	logic opmOn;
	logic matchOne;
	logic matchTwo;
	logic capOneEvt;
	logic [7:0] idx;
	logic [16:0] sum;
	logic [4:0] setF;
	logic [4:0] clrF;

	ctt_edge_sync capOneSync (
		.clk(clk),
		.srst(srst),
		.pinIn(capturePinOne),
		.risingSel(st.cr1[B_EDGE_ONE]),
		.pulse(capEdgeOne)
	);

	ctt_edge_sync capTwoSync (
		.clk(clk),
		.srst(srst),
		.pinIn(capturePinTwo),
		.risingSel(st.cr2[B_EDGE_TWO]),
		.pulse(capEdgeTwo)
	);

	ctt_edge_sync extSync (
		.clk(clk),
		.srst(srst),
		.pinIn(extClockPin),
		.risingSel(st.cr2[B_EXT_EDGE]),
		.pulse(extEdge)
	);

	// prescaler stops in halt and while disabled
	ctt_prescaler #(
		.EXT_PRESENT(EXT_PRESENT)
	) prescaler (
		.clk(clk),
		.srst(srst),
		.run(~haltMode & ~st.timd),
		.clockSelect(st.cr2[B_CLK_HI:B_CLK_LO]),
		.extEdge(extEdge),
		.tick(tick)
	);

	always_comb
	begin
		next_st = st;
		setF = '0;
		clrF = '0;
		live = ~haltMode;
		idx = 8'(wbAdr >> 2);
		access = wbCyc & wbStb & ~st.ack;
		wr = access & wbWe & wbSel[0] & live;
		rd = access & ~wbWe & live;
		pwmOn = st.cr2[B_PWM];
		opmOn = st.cr2[B_SINGLE_PULSE] & ~pwmOn;
		matchOne = tick & ~st.inhibit[0] & (st.count == (pwmOn ? st.actOne : st.cmpOne));
		matchTwo = tick & ~st.inhibit[1] & (st.count == (pwmOn ? st.actTwo : st.cmpTwo));
		capOneEvt = capEdgeOne & ~pwmOn;
		next_st.ack = access;
		next_st.haltPrev = haltMode;
		// bus read mux
		if (rd)
		begin
			case (idx)
				IDX_CR2: next_st.rdat = st.cr2;
				IDX_CR1: next_st.rdat = st.cr1;
				IDX_CSR: next_st.rdat = {st.flags, st.timd, 2'h0};
				IDX_IC1H: next_st.rdat = st.capOne[15:8];
				IDX_IC1L: next_st.rdat = st.capOne[7:0];
				IDX_OC1H: next_st.rdat = st.cmpOne[15:8];
				IDX_OC1L: next_st.rdat = st.cmpOne[7:0];
				IDX_CH, IDX_ACH: next_st.rdat = st.count[15:8];
				IDX_CL, IDX_ACL: next_st.rdat = st.count[7:0];
				IDX_IC2H: next_st.rdat = st.capTwo[15:8];
				IDX_IC2L: next_st.rdat = st.capTwo[7:0];
				IDX_OC2H: next_st.rdat = st.cmpTwo[15:8];
				IDX_OC2L: next_st.rdat = st.cmpTwo[7:0];
				default: next_st.rdat = 8'h00;
			endcase
		end
		// counter advance and wrap
		sum = 17'(st.count) + 17'h1;
		if (tick)
		begin
			next_st.count = sum[15:0];
			setF[F_OVF] = sum[16];
		end
		// compare and capture per mode; pwm branch sets no compare flags
		if (pwmOn)
		begin
			if (matchOne)
			begin
				next_st.pinOne = st.cr1[B_LVL_ONE];
			end
			if (matchTwo)
			begin
				next_st.count = COUNT_RESET;
				next_st.pinOne = st.cr1[B_LVL_TWO];
				setF[F_CAP1] = 1'b1;
				next_st.actOne = st.cmpOne;
				next_st.actTwo = st.cmpTwo;
			end
		end
		else
		begin
			next_st.actOne = st.cmpOne;
			next_st.actTwo = st.cmpTwo;
			if (matchOne)
			begin
				next_st.pinOne = st.cr1[B_LVL_ONE];
				setF[F_CMP1] = ~opmOn;
			end
			if (matchTwo)
			begin
				setF[F_CMP2] = 1'b1;
				if (!opmOn)
				begin
					next_st.pinTwo = st.cr1[B_LVL_TWO];
				end
			end
			if (capOneEvt && live)
			begin
				setF[F_CAP1] = 1'b1;
				if (opmOn)
				begin
					next_st.count = COUNT_RESET;
					next_st.capOne = SINGLE_CAPTURE;
					next_st.pinOne = st.cr1[B_LVL_TWO];
				end
				else
				begin
					next_st.capOne = st.count;
				end
			end
		end
		if (capEdgeTwo && live)
		begin
			setF[F_CAP2] = 1'b1;
			next_st.capTwo = st.count;
		end
		// halt: edges arm, exit by interrupt captures the held count
		if (haltMode)
		begin
			next_st.capArm = st.capArm | {capEdgeTwo, capOneEvt};
		end
		else if (st.haltPrev)
		begin
			next_st.capArm = 2'h0;
			if (st.capArm[0])
			begin
				setF[F_CAP1] = 1'b1;
				next_st.capOne = st.count;
			end
			if (st.capArm[1])
			begin
				setF[F_CAP2] = 1'b1;
				next_st.capTwo = st.count;
			end
		end
		// register writes
		if (wr)
		begin
			case (idx)
				IDX_CR1:
				begin
					next_st.cr1 = wbDatI[7:0];
					if (wbDatI[B_FORCE_ONE] && st.cr2[B_PIN_ONE_EN])
					begin
						next_st.pinOne = wbDatI[B_LVL_ONE];
					end
					if (wbDatI[B_FORCE_TWO] && st.cr2[B_PIN_TWO_EN])
					begin
						next_st.pinTwo = wbDatI[B_LVL_TWO];
					end
				end
				IDX_CR2: next_st.cr2 = wbDatI[7:0];
				IDX_CSR: next_st.timd = wbDatI[B_TIMD];
				IDX_OC1H:
				begin
					next_st.cmpOne[15:8] = wbDatI[7:0];
					next_st.inhibit[0] = 1'b1;
				end
				IDX_OC1L:
				begin
					next_st.cmpOne[7:0] = wbDatI[7:0];
					next_st.inhibit[0] = 1'b0;
				end
				IDX_OC2H:
				begin
					next_st.cmpTwo[15:8] = wbDatI[7:0];
					next_st.inhibit[1] = 1'b1;
				end
				IDX_OC2L:
				begin
					next_st.cmpTwo[7:0] = wbDatI[7:0];
					next_st.inhibit[1] = 1'b0;
				end
				IDX_CL, IDX_ACL: next_st.count = COUNT_RESET;
				default: next_st.cr1 = st.cr1;
			endcase
		end
		// two-step flag clearing; a set in the same cycle wins
		if (rd && idx == IDX_CSR)
		begin
			next_st.srSeen = st.flags;
		end
		for (int k = 0; k < 5; k++)
		begin
			if (access && live && idx == FLAG_CLR_IDX[k] && st.srSeen[k])
			begin
				clrF[k] = 1'b1;
				next_st.srSeen[k] = 1'b0;
			end
		end
		next_st.flags = (st.flags & ~clrF) | setF;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st <= '0;
			st.cr1 <= CTRL_RESET;
			st.cr2 <= CTRL_RESET;
			st.count <= COUNT_RESET;
			st.cmpOne <= CMP_RESET;
			st.cmpTwo <= CMP_RESET;
			st.actOne <= CMP_RESET;
			st.actTwo <= CMP_RESET;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign wbAck = st.ack;
	assign wbDatO = {24'h000000, st.rdat};
	assign comparePinOne = st.pinOne;
	assign comparePinTwo = st.pinTwo;
	assign comparePinOneEn = st.cr2[B_PIN_ONE_EN] & ~st.timd;
	assign comparePinTwoEn = st.cr2[B_PIN_TWO_EN] & ~st.timd;
	assign timerIrq = ~cpuIntMask & ((st.cr1[B_CAP_IRQ_EN] & (st.flags[F_CAP1] | st.flags[F_CAP2]))
		| (st.cr1[B_CMP_IRQ_EN] & (st.flags[F_CMP1] | st.flags[F_CMP2]))
		| (st.cr1[B_OVF_IRQ_EN] & st.flags[F_OVF]));
	// halt has no timer wake path
	assign waitWake = waitMode & timerIrq;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	irq_mask_gate_a: assert property (timerIrq |-> !cpuIntMask) else $error("irq raised while masked");
	cap_irq_on_a: assert property ((st.cr1[B_CAP_IRQ_EN] && st.flags[F_CAP2] && !cpuIntMask) |-> timerIrq)
		else $error("capture irq missing");
	cmp_irq_on_a: assert property ((st.cr1[B_CMP_IRQ_EN] && st.flags[F_CMP1] && !cpuIntMask) |-> timerIrq)
		else $error("compare irq missing");
	ovf_irq_on_a: assert property ((st.cr1[B_OVF_IRQ_EN] && st.flags[F_OVF] && !cpuIntMask) |-> waitWake || !waitMode)
		else $error("overflow wake missing");
	pwm_no_cmp_a: assert property (pwmOn |=> !$rose(st.flags[F_CMP1]) && !$rose(st.flags[F_CMP2]))
		else $error("compare flag in pwm");
	halt_freeze_a: assert property (haltMode |=> $stable(st.count) && $stable(st.cr1) && $stable(st.flags))
		else $error("timer moved in halt");
	halt_capture_a: assert property ((!haltMode && st.haltPrev && st.capArm[0]) |=> st.flags[F_CAP1]
		&& st.capOne == $past(st.count)) else $error("halt exit capture lost");
	ctrl_reset_a: assert property ($past(srst) |-> st.cr1 == CTRL_RESET && st.cr2 == CTRL_RESET)
		else $error("control reset value");
	ovf_wrap_a: assert property (($past(st.count) == COUNT_MAX && st.count == 16'h0000) |-> st.flags[F_OVF])
		else $error("wrap without overflow");
	pulse_start_a: assert property ((opmOn && capEdgeOne && live && !wr) |=> st.count == COUNT_RESET
		&& st.capOne == SINGLE_CAPTURE && st.pinOne == $past(st.cr1[B_LVL_TWO])) else $error("pulse start");
	pin_route_a: assert property (comparePinOneEn == (st.cr2[B_PIN_ONE_EN] && !st.timd))
		else $error("pin one routing");
	cover_pulse_c: cover property (opmOn && capEdgeOne && live);
	cover_period_c: cover property (pwmOn && matchTwo);
	cover_clear_c: cover property ($fell(st.flags[F_OVF]));
	cover_wake_c: cover property (!haltMode && st.haltPrev && st.capArm != 2'h0);
endmodule
`default_nettype wire

// [verif/ctt_pin_model.sv]
// far side model: capture input sources, external clock source and compare pin watcher
`default_nettype none
module ctt_pin_model
(
	input wire logic clk,
	output logic capOne,
	output logic capTwo,
	output logic extClk,
	input wire logic cmpOne,
	input wire logic cmpOneEn,
	output logic [7:0] onesSeen
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		capOne = 1'b0;
		capTwo = 1'b0;
		extClk = 1'b0;
		onesSeen = 8'h00;
	end
	// capture one is only driven outside pwm, capture two left idle in single pulse mode
	task automatic setCap(input logic which, input logic v);
		@(posedge clk);
		if (which)
			capTwo <= v;
		else
			capOne <= v;
	endtask
	// counts cycles where the timer drives compare pin one high
	always @(posedge clk)
	begin
		if (cmpOneEn === 1'b1 && cmpOne === 1'b1)
			onesSeen <= onesSeen + 8'h01;
	end
endmodule
`default_nettype wire

// [verif/tb_capture_compare_timer16.sv]
// self-checking bench of the capture/compare timer over wishbone
`default_nettype none
module tb_capture_compare_timer16;
	import ctt_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, srst, wbCyc, wbStb, wbWe, cpuIntMask, waitMode, haltMode;
	logic [9:0] wbAdr;
	logic [3:0] wbSel;
	logic [31:0] wbDatI, wbDatO;
	logic wbAck, capOne, capTwo, extClk, pinOne, pinOneEn, pinTwo, pinTwoEn, timerIrq, waitWake;
	logic [7:0] onesSeen, q, a;
	int num_errors = 0;
	int n_compared = 0;
	ctt_timer16 #(.ADR_W(10), .EXT_PRESENT(1'b1)) dut (.clk(clk), .srst(srst), .wbCyc(wbCyc), .wbStb(wbStb),
		.wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
		.capturePinOne(capOne), .capturePinTwo(capTwo), .extClockPin(extClk), .comparePinOne(pinOne),
		.comparePinOneEn(pinOneEn), .comparePinTwo(pinTwo), .comparePinTwoEn(pinTwoEn),
		.cpuIntMask(cpuIntMask), .waitMode(waitMode), .haltMode(haltMode), .timerIrq(timerIrq),
		.waitWake(waitWake));
	ctt_pin_model partner (.clk(clk), .capOne(capOne), .capTwo(capTwo), .extClk(extClk), .cmpOne(pinOne),
		.cmpOneEn(pinOneEn), .onesSeen(onesSeen));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic final_report();
		if (num_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] r);
		int n;
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= {idx, 2'b00};
		wbDatI <= {24'h000000, d};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wbAck !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			num_errors++;
			final_report();
		end
		r = wbDatO[7:0];
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] r;
		wb(1'b1, idx, d, r);
	endtask
	task automatic rd(input logic [7:0] idx, output logic [7:0] r);
		wb(1'b0, idx, 8'h00, r);
	endtask
	task automatic s_regs();
		rd(IDX_CR1, q);
		chk("cr1 reset", CTRL_RESET, q);
		rd(IDX_CR2, q);
		chk("cr2 reset", CTRL_RESET, q);
		wr(IDX_CR1, 8'hA5);
		rd(IDX_CR1, q);
		chk("cr1 rw", 8'hA5, q);
		wr(IDX_CR1, 8'h00);
		rd(8'h60, q);
		chk("unmapped", 8'h00, q);
	endtask
	task automatic s_capture();
		wr(IDX_CR1, 8'h82);
		partner.setCap(1'b0, 1'b1);
		waitc(8);
		rd(IDX_CSR, q);
		chk("cap flag rising", 8'h01, q[7]);
		chk("irq capture", 8'h01, timerIrq);
		cpuIntMask <= 1'b1;
		waitc(2);
		chk("irq masked", 8'h00, timerIrq);
		cpuIntMask <= 1'b0;
		waitMode <= 1'b1;
		waitc(2);
		chk("wait wake", 8'h01, waitWake);
		waitMode <= 1'b0;
		rd(IDX_IC1L, q);
		chk("flag clear", 8'h00, timerIrq);
		partner.setCap(1'b0, 1'b0);
		waitc(8);
		rd(IDX_CSR, q);
		chk("falling ignored", 8'h00, q[7]);
		wr(IDX_CR1, 8'h00);
		partner.setCap(1'b0, 1'b1);
		waitc(8);
		partner.setCap(1'b0, 1'b0);
		waitc(8);
		rd(IDX_CSR, q);
		chk("cap flag falling", 8'h01, q[7]);
		chk("irq off", 8'h00, timerIrq);
	endtask
	task automatic s_overflow();
		wr(IDX_CR2, {4'h0, CLK_DIV2, 2'b00});
		wr(IDX_CR1, 8'h20);
		rd(IDX_CSR, q);
		wr(IDX_CL, 8'h00);
		chk("overflow cleared", 8'h00, timerIrq);
		waitc(30);
		rd(IDX_CSR, q);
		chk("overflow flag", 8'h01, q[5]);
		chk("irq overflow", 8'h01, timerIrq);
		rd(IDX_CL, q);
		chk("overflow clear", 8'h00, timerIrq);
	endtask
	task automatic s_force();
		wr(IDX_CR2, 8'h00);
		wr(IDX_CR1, 8'h09);
		waitc(2);
		chk("force no enable", 8'h00, pinOne);
		wr(IDX_CR2, 8'hC0);
		wr(IDX_CR1, 8'h09);
		waitc(2);
		chk("pin one enable", 8'h01, pinOneEn);
		chk("force one", 8'h01, pinOne);
		wr(IDX_CR1, 8'h14);
		waitc(2);
		chk("force two", 8'h01, pinTwo);
		chk("pin two enable", 8'h01, pinTwoEn);
	endtask
	task automatic s_pulse();
		wr(IDX_CR1, 8'h0E);
		wr(IDX_OC1H, 8'h00);
		wr(IDX_OC1L, 8'h02);
		wr(IDX_CR2, 8'hA4);
		a = onesSeen;
		partner.setCap(1'b0, 1'b1);
		waitc(7);
		chk("pulse start", 8'h01, pinOne);
		waitc(40);
		chk("pulse end", 8'h00, pinOne);
		q = onesSeen - a;
		chk("pulse width", 8'h01, {7'h00, (q >= 8'h0C) && (q <= 8'h0F)});
		rd(IDX_CSR, q);
		chk("no cmp one flag", 8'h00, q[6]);
		rd(IDX_IC1L, q);
		chk("capture fixed", SINGLE_CAPTURE[7:0], q);
		partner.setCap(1'b0, 1'b0);
		wr(IDX_CR2, 8'h84);
		wr(IDX_CR1, 8'h41);
		wr(IDX_CL, 8'h00);
		waitc(30);
		chk("match level one", 8'h01, pinOne);
		chk("irq compare", 8'h01, timerIrq);
	endtask
	task automatic s_halt();
		wr(IDX_CR1, 8'h00);
		wr(IDX_CR2, {4'h0, CLK_DIV8, 2'b10});
		rd(IDX_CL, a);
		haltMode <= 1'b1;
		partner.setCap(1'b1, 1'b1);
		waitc(400);
		haltMode <= 1'b0;
		rd(IDX_CL, q);
		chk("halt freeze", 8'h01, {7'h00, (q - a) < 8'h10});
		rd(IDX_CSR, q);
		chk("halt capture", 8'h01, q[4]);
	endtask
	initial
	begin
		srst = 1'b1;
		wbCyc = 1'b0;
		wbStb = 1'b0;
		wbWe = 1'b0;
		wbAdr = 10'h000;
		wbSel = 4'hF;
		wbDatI = 32'h00000000;
		cpuIntMask = 1'b0;
		waitMode = 1'b0;
		haltMode = 1'b0;
		waitc(4);
		srst <= 1'b0;
		s_regs();
		s_capture();
		s_overflow();
		s_force();
		s_pulse();
		s_halt();
		final_report();
	end
endmodule
`default_nettype wire
